/* msm_pkg.sv */
// Package for the modem status and multi-function pin block.
// Assumes one clock domain; the register port that reads the
// modem status register lives outside this block.
`default_nettype none

package msm_pkg;

    // ----------------------------------------------------------------
    // Modem status register bit positions
    // ----------------------------------------------------------------
    localparam int unsigned CTS_DELTA_BIT  = 0;  // Clear-to-send changed
    localparam int unsigned DSR_DELTA_BIT  = 1;  // Data-set-ready changed
    localparam int unsigned RI_EDGE_BIT    = 2;  // Ring ended (pin rose)
    localparam int unsigned DCD_DELTA_BIT  = 3;  // Carrier detect changed
    localparam int unsigned CTS_STATE_BIT  = 4;  // Clear-to-send active
    localparam int unsigned DSR_STATE_BIT  = 5;  // Data-set-ready active
    localparam int unsigned RI_STATE_BIT   = 6;  // Ring active
    localparam int unsigned DCD_STATE_BIT  = 7;  // Carrier detect active

    // ----------------------------------------------------------------
    // Modem input lanes, in the order of the status bits
    // ----------------------------------------------------------------
    localparam int unsigned LANE_CTS       = 0;
    localparam int unsigned LANE_DSR       = 1;
    localparam int unsigned LANE_RI        = 2;
    localparam int unsigned LANE_DCD       = 3;
    localparam int unsigned LANE_COUNT     = 4;

    // ----------------------------------------------------------------
    // Multi-function pin source selection (alternate function bits 2:1)
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MSM_SEL_AUX   = 2'h0,  // User auxiliary output
        MSM_SEL_RATE  = 2'h1,  // Sixteen-times rate clock
        MSM_SEL_DMA   = 2'h2,  // Receive DMA request
        MSM_SEL_SPARE = 2'h3   // Unused code, falls back to auxiliary
    } msm_sel_type;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET   = 8'h00;  // No deltas, pins idle
    localparam logic       PIN_IDLE       = 1'h1;   // Modem inputs idle high
    localparam logic       AUX_INACTIVE   = 1'h1;   // Auxiliary idles high
    localparam int unsigned SYNC_STAGES   = 2;      // Synchroniser depth
    localparam logic [15:0] DIVISOR_RESET = 16'h0001;

endpackage : msm_pkg

`default_nettype wire

/* msm_modem_status.sv */
// Modem status capture, change flags, modem-status interrupt and the
// multi-function pin mux with its sixteen-times rate generator.
// Assumes modem inputs are asynchronous, the register read strobe and
// control levels are synchronous to ref_clk_i.
//
// Behaviour
// - Status bit 5 is inverted DSR
// - Bit 1 flags DSR change since read
// - Status bit 7 is inverted DCD
// - Bit 3 flags DCD change since read
// - DCD never affects the receiver
// - Status bit 6 is inverted RI
// - Bit 2 set only on RI rise
// - DSR or DCD change raises interrupt
// - RI trailing edge only raises interrupt
// - Select bits pick one pin source
// - Auxiliary output selected after reset
// - Control bit 3 drives auxiliary low, except in loopback where it stays high
// - Reset forces auxiliary high
// - Rate clock is input clock over divisor; divisor 0 or 1 gives half the input clock
// - Rate clock is internal receiver clock
// - Pin may carry receive DMA request
// - Bit 4 inverted CTS, bit 0 change
`timescale 1ns/1ps
`default_nettype none

module msm_modem_status #(
    parameter int unsigned DIV_WIDTH = 16  // Divisor latch width
) (
    input  wire logic                 ref_clk_i,       // 10 MHz clock
    input  wire logic                 reset_i,         // Master reset
    input  wire logic                 cts_n_i,         // Clear-to-send pin
    input  wire logic                 dsr_n_i,         // Data-set-ready pin
    input  wire logic                 ri_n_i,          // Ring pin
    input  wire logic                 dcd_n_i,         // Carrier pin
    input  wire logic                 status_read_i,   // Status register read
    input  wire logic                 msi_enable_i,    // Modem interrupt enable
    input  wire logic                 aux_control_i,   // Control register bit 3
    input  wire logic                 loopback_i,      // Loopback mode
    input  wire logic [1:0]           alt_select_i,    // Alternate bits 2:1
    input  wire logic [DIV_WIDTH-1:0] divisor_i,       // Divisor latches
    input  wire logic                 receive_dma_request_i, // From FIFO
    output logic [7:0]                modem_status_register_o,
    output logic                      modem_irq_o,     // Modem interrupt
    output logic                      multi_function_pin_o,
    output logic                      sixteen_x_rate_clock_o,
    output logic                      receiver_clock_o // Receiver tick
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [msm_pkg::LANE_COUNT-1:0] raw_pins;    // Pins gathered
    logic [msm_pkg::LANE_COUNT-1:0] sync_first;  // First sync stage
    logic [msm_pkg::LANE_COUNT-1:0] sync_pins;   // Synchronised pins
    logic [msm_pkg::LANE_COUNT-1:0] prev_pins;   // Previous sample
    logic [msm_pkg::LANE_COUNT-1:0] change;      // Per-lane event
    logic [msm_pkg::SYNC_STAGES-1:0] settle;     // Chain fill tracker
    logic                           armed;       // Edge detect allowed
    logic [3:0]                     deltas;      // Sticky change flags
    logic [3:0]                     next_deltas; // Flags after update
    logic                           irq_event;   // Interrupting event
    logic [DIV_WIDTH-1:0]           rate_count;  // Divider count
    logic                           rate_level;  // Divided clock level
    logic                           rate_wrap;   // End of rate period
    logic                           aux_level;   // Auxiliary pin level
    msm_pkg::msm_sel_type           sel;         // Decoded selection

    assign raw_pins[msm_pkg::LANE_CTS] = cts_n_i;
    assign raw_pins[msm_pkg::LANE_DSR] = dsr_n_i;
    assign raw_pins[msm_pkg::LANE_RI]  = ri_n_i;
    assign raw_pins[msm_pkg::LANE_DCD] = dcd_n_i;

    // ----------------------------------------------------------------
    // Input synchronisers, one per modem lane
    // ----------------------------------------------------------------
    // Three flops per lane; only the second and third stages are looked at
    genvar lane;
    generate
        for (lane = 0; lane < msm_pkg::LANE_COUNT; lane++)
        begin : g_sync
            always_ff @(posedge ref_clk_i or posedge reset_i)
            begin
                if (reset_i)
                begin
                    sync_first[lane] <= msm_pkg::PIN_IDLE;
                    sync_pins[lane]  <= msm_pkg::PIN_IDLE;
                    prev_pins[lane]  <= msm_pkg::PIN_IDLE;
                end
                else
                begin
                    sync_first[lane] <= raw_pins[lane];
                    sync_pins[lane]  <= sync_first[lane];
                    prev_pins[lane]  <= sync_pins[lane];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Settling after reset
    // ----------------------------------------------------------------
    // Idle-high reset values would fake an edge on a pin held low, so
    // edges count only once the chain holds real samples
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            settle <= '0;
        else
            settle <= {settle[msm_pkg::SYNC_STAGES-2:0], 1'h1};
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            armed <= 1'h0;
        else
            armed <= settle[msm_pkg::SYNC_STAGES-1];
    end

    // ----------------------------------------------------------------
    // Change detection
    // ----------------------------------------------------------------
    always_comb
    begin
        change                    = armed ? (sync_pins ^ prev_pins) : '0;
        // Ring counts only as the pin rises, i.e. ring ends
        change[msm_pkg::LANE_RI]  = armed & sync_pins[msm_pkg::LANE_RI]
                                  & ~prev_pins[msm_pkg::LANE_RI];
    end

    // Sticky flags: a new event wins over the clear of the same read
    always_comb
    begin
        next_deltas = status_read_i ? 4'h0 : deltas;
        next_deltas = next_deltas | change;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            deltas <= 4'h0;
        else
            deltas <= next_deltas;
    end

    // ----------------------------------------------------------------
    // Modem status register
    // ----------------------------------------------------------------
    // Carrier detect ends here only; nothing routes it to the receiver
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            modem_status_register_o <= msm_pkg::STATUS_RESET;
        else
        begin
            modem_status_register_o[msm_pkg::CTS_DELTA_BIT] <=
                next_deltas[msm_pkg::LANE_CTS];
            modem_status_register_o[msm_pkg::DSR_DELTA_BIT] <=
                next_deltas[msm_pkg::LANE_DSR];
            modem_status_register_o[msm_pkg::RI_EDGE_BIT]   <=
                next_deltas[msm_pkg::LANE_RI];
            modem_status_register_o[msm_pkg::DCD_DELTA_BIT] <=
                next_deltas[msm_pkg::LANE_DCD];
            modem_status_register_o[msm_pkg::CTS_STATE_BIT] <=
                ~sync_pins[msm_pkg::LANE_CTS];
            modem_status_register_o[msm_pkg::DSR_STATE_BIT] <=
                ~sync_pins[msm_pkg::LANE_DSR];
            modem_status_register_o[msm_pkg::RI_STATE_BIT]  <=
                ~sync_pins[msm_pkg::LANE_RI];
            modem_status_register_o[msm_pkg::DCD_STATE_BIT] <=
                ~sync_pins[msm_pkg::LANE_DCD];
        end
    end

    // ----------------------------------------------------------------
    // Modem-status interrupt
    // ----------------------------------------------------------------
    // Pending while any flag stands; ring only flags on its trailing
    // edge, so its leading edge never interrupts
    assign irq_event = |next_deltas;

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            modem_irq_o <= 1'h0;
        else
            modem_irq_o <= msi_enable_i & irq_event;
    end

    // ----------------------------------------------------------------
    // Sixteen-times rate generator
    // ----------------------------------------------------------------
    // Count runs 0 .. divisor-1; divisor 0 is treated as 1. At
    // divisor 1 the level can only toggle each clock, so the pin then
    // shows half the input rate while the receiver tick stays exact.
    assign rate_wrap = (rate_count >= divisor_i - DIV_WIDTH'(1))
                     || (divisor_i == '0);

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rate_count <= '0;
        else if (rate_wrap)
            rate_count <= '0;
        else
            rate_count <= rate_count + DIV_WIDTH'(1);
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rate_level <= 1'h0;
        else if (divisor_i <= DIV_WIDTH'(1))
            rate_level <= ~rate_level;
        else
            rate_level <= (rate_count < (divisor_i >> 1));
    end

    // Receiver clock is the rate tick, one clock wide per period
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            receiver_clock_o <= 1'h0;
        else
            receiver_clock_o <= rate_wrap;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            sixteen_x_rate_clock_o <= 1'h0;
        else
            sixteen_x_rate_clock_o <= rate_level;
    end

    // ----------------------------------------------------------------
    // Multi-function pin
    // ----------------------------------------------------------------
    // Auxiliary is active low; loopback forces it inactive
    assign aux_level = (aux_control_i && !loopback_i) ? 1'h0
                     : msm_pkg::AUX_INACTIVE;
    assign sel       = msm_pkg::msm_sel_type'(alt_select_i);

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            multi_function_pin_o <= msm_pkg::AUX_INACTIVE;
        else
        begin
            case (sel)
                msm_pkg::MSM_SEL_RATE:
                    multi_function_pin_o <= rate_level;
                msm_pkg::MSM_SEL_DMA:
                    multi_function_pin_o <= receive_dma_request_i;
                default:
                    multi_function_pin_o <= aux_level;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // A falling pin shows as a set state bit one edge later
    AST_DSR_STATE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $fell(sync_pins[msm_pkg::LANE_DSR]) |=>
            modem_status_register_o[msm_pkg::DSR_STATE_BIT])
        else $error("DSR state bit not set after pin fell");

    // A change seen by the armed detector shows in the delta bit at the
    // next edge; a read in that same cycle loses to the event
    AST_DSR_DELTA: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (armed && $changed(sync_pins[msm_pkg::LANE_DSR])) |=>
            modem_status_register_o[msm_pkg::DSR_DELTA_BIT])
        else $error("DSR change not flagged");

    // State bit always mirrors the inverted synchronised pin of the
    // previous edge, in both directions
    AST_DCD_STATE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        modem_status_register_o[msm_pkg::DCD_STATE_BIT]
            == ~$past(sync_pins[msm_pkg::LANE_DCD]))
        else $error("DCD state bit wrong");

    // Same timing as the data-set-ready delta above
    AST_DCD_DELTA: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (armed && $changed(sync_pins[msm_pkg::LANE_DCD])) |=>
            modem_status_register_o[msm_pkg::DCD_DELTA_BIT])
        else $error("DCD change not flagged");

    // Ring starting (state bit rising) must leave a clear ring edge flag
    // clear; only the end of a ring may set it, and so interrupt.
    // Watched on the register outputs so the edge logic is not trusted
    AST_RI_LEAD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ($rose(modem_status_register_o[msm_pkg::RI_STATE_BIT])
            && !$past(modem_status_register_o[msm_pkg::RI_EDGE_BIT])) |->
            !modem_status_register_o[msm_pkg::RI_EDGE_BIT])
        else $error("Ring flag set without trailing edge");

    AST_RI_STATE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        modem_status_register_o[msm_pkg::RI_STATE_BIT]
            == ~$past(sync_pins[msm_pkg::LANE_RI]))
        else $error("Ring state bit wrong");

    // Any flagged event with the enable up interrupts at the next edge,
    // even when a status read falls in the same cycle
    AST_IRQ_RAISE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (msi_enable_i && |change) |=> modem_irq_o)
        else $error("Modem interrupt not raised on change");

    // A quiet read leaves no flag and no pending interrupt
    AST_READ_CLEAR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (status_read_i && !(|change)) |=> (deltas == 4'h0) && !modem_irq_o)
        else $error("Status read did not clear flags");

    // Pin mux answers one edge after its inputs; the auxiliary level is
    // the only source that software sets directly
    AST_AUX_ACTIVE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (sel == msm_pkg::MSM_SEL_AUX && aux_control_i && !loopback_i) |=>
            !multi_function_pin_o)
        else $error("Auxiliary not driven low");

    AST_AUX_LOOP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (sel == msm_pkg::MSM_SEL_AUX && loopback_i) |=> multi_function_pin_o)
        else $error("Auxiliary active during loopback");

    // Request passes with one flop of delay and no other shaping
    AST_DMA_ROUTE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (sel == msm_pkg::MSM_SEL_DMA) |=>
            multi_function_pin_o == $past(receive_dma_request_i))
        else $error("DMA request not routed to pin");

    // With the divisor held at four, the next tick comes exactly four
    // edges after the last one, with none in between; a divisor change
    // inside that span drops the check
    AST_RATE_TICK: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (divisor_i == 16'h0004 && rate_wrap) ##1 (divisor_i == 16'h0004) [*4]
            |-> rate_wrap && !$past(rate_wrap) && !$past(rate_wrap, 2)
                && !$past(rate_wrap, 3))
        else $error("Rate period differs from divisor");

endmodule : msm_modem_status

`default_nettype wire

/* msm_modem_peer.sv */
// Behavioural model of the remote modem driving the four status pins.
// Assumes the bench states the wanted pin levels just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Remote modem pins
// ----------------------------------------------------------------
module msm_modem_peer (
    input  wire logic       ref_clk_i,    // Bench clock
    input  wire logic       reset_i,      // Master reset
    input  wire logic [3:0] level_cmd_i,  // Wanted levels, lane order
    output logic      [3:0] pins_n_o      // Active-low modem pins
);

    // Pins move only on a clock edge, so every change is a clean level
    // step; all lanes idle high while the link is held in reset
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            pins_n_o <= 4'hf;         // Idle, nothing asserted
        else
            pins_n_o <= level_cmd_i;  // Follow the bench command
    end

endmodule // msm_modem_peer

`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the modem status and multi-function pin block.
// Assumes msm_pkg, the design and msm_modem_peer are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        ref_clk_i;      // 10 MHz clock
    logic        reset_i;        // Master reset
    logic [3:0]  pin_cmd;        // Peer pin command, lane order
    logic [3:0]  pins_n;         // Peer pins
    logic        status_read_i;  // Status read strobe
    logic        msi_enable_i;   // Modem interrupt enable
    logic        aux_control_i;  // Control bit 3
    logic        loopback_i;     // Loopback mode
    logic [1:0]  alt_select_i;   // Pin source select
    logic [15:0] divisor_i;      // Divisor latches
    logic        dma_req;        // Receive DMA request
    logic [7:0]  status;         // Modem status register
    logic        irq;            // Modem interrupt
    logic        mf;             // Multi-function pin
    logic        rate;           // Sixteen-times rate clock
    logic        rx_tick;        // Receiver clock tick
    int          fail_count;     // Mismatches
    int          cmp_count;      // Comparisons

    msm_modem_peer peer (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .level_cmd_i (pin_cmd),
        .pins_n_o    (pins_n)
    );

    msm_modem_status dut (
        .ref_clk_i               (ref_clk_i),
        .reset_i                 (reset_i),
        .cts_n_i                 (pins_n[msm_pkg::LANE_CTS]),
        .dsr_n_i                 (pins_n[msm_pkg::LANE_DSR]),
        .ri_n_i                  (pins_n[msm_pkg::LANE_RI]),
        .dcd_n_i                 (pins_n[msm_pkg::LANE_DCD]),
        .status_read_i           (status_read_i),
        .msi_enable_i            (msi_enable_i),
        .aux_control_i           (aux_control_i),
        .loopback_i              (loopback_i),
        .alt_select_i            (alt_select_i),
        .divisor_i               (divisor_i),
        .receive_dma_request_i   (dma_req),
        .modem_status_register_o (status),
        .modem_irq_o             (irq),
        .multi_function_pin_o    (mf),
        .sixteen_x_rate_clock_o  (rate),
        .receiver_clock_o        (rx_tick)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Wait n edges, then 10 ns so the edge's updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #10;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
        end
    endtask

    // One-cycle read strobe; flags clear at the edge that samples it
    task automatic read_status;
        status_read_i = 1'b1;
        step(1);
        status_read_i = 1'b0;
        step(1);
    endtask

    // Peer moves at edge 1, status lands 3 edges later; 5 gives margin
    task automatic set_pin(input int lane, input logic level);
        pin_cmd[lane] = level;
        step(5);
    endtask

    task automatic wrap_up;
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        check(status, 8'h00);
        check({7'h0, irq}, 8'h00);
        check({7'h0, mf}, 8'h01);
    endtask

    task automatic t_dsr;
        msi_enable_i = 1'b1;
        set_pin(msm_pkg::LANE_DSR, 1'b0);
        check(status, 8'h22);
        check({7'h0, irq}, 8'h01);
        read_status();
        check(status, 8'h20);
        check({7'h0, irq}, 8'h00);
        set_pin(msm_pkg::LANE_DSR, 1'b1);
        check(status, 8'h02);
        check({7'h0, irq}, 8'h01);
        read_status();
    endtask

    // Interrupt masked first: the flag must wait for the enable
    task automatic t_dcd;
        msi_enable_i = 1'b0;
        set_pin(msm_pkg::LANE_DCD, 1'b0);
        check(status, 8'h88);
        check({7'h0, irq}, 8'h00);
        msi_enable_i = 1'b1;
        step(1);
        check({7'h0, irq}, 8'h01);
        read_status();
        set_pin(msm_pkg::LANE_DCD, 1'b1);
        check(status, 8'h08);
        read_status();
    endtask

    // Ring start must not flag; only its end flags and interrupts
    task automatic t_ri;
        set_pin(msm_pkg::LANE_RI, 1'b0);
        check(status, 8'h40);
        check({7'h0, irq}, 8'h00);
        set_pin(msm_pkg::LANE_RI, 1'b1);
        check(status, 8'h04);
        check({7'h0, irq}, 8'h01);
        read_status();
        check(status, 8'h00);
    endtask

    task automatic t_cts;
        set_pin(msm_pkg::LANE_CTS, 1'b0);
        check(status, 8'h11);
        read_status();
        check(status, 8'h10);
        set_pin(msm_pkg::LANE_CTS, 1'b1);
        check(status, 8'h01);
        read_status();
    endtask

    task automatic t_mux;
        alt_select_i = 2'h2;
        dma_req = 1'b1;
        step(1);
        check({7'h0, mf}, 8'h01);
        dma_req = 1'b0;
        step(1);
        check({7'h0, mf}, 8'h00);
        alt_select_i = 2'h0;
        aux_control_i = 1'b1;
        step(1);
        check({7'h0, mf}, 8'h00);
        loopback_i = 1'b1;
        step(1);
        check({7'h0, mf}, 8'h01);
        loopback_i = 1'b0;
        alt_select_i = 2'h3;
        step(1);
        check({7'h0, mf}, 8'h00);
        aux_control_i = 1'b0;
        step(1);
        check({7'h0, mf}, 8'h01);
    endtask

    // Count rises over 40 clocks; each divisor period gives exactly one
    task automatic t_rate;
        int   d;
        int   cr;
        int   cm;
        int   cx;
        logic pr;
        logic pm;
        alt_select_i = 2'h1;
        for (d = 4; d <= 5; d++)
        begin
            divisor_i = 16'(d);
            step(10);
            pr = rate;
            pm = mf;
            cr = 0;
            cm = 0;
            cx = 0;
            // Carrier moves inside the window; the tick must not notice
            pin_cmd[msm_pkg::LANE_DCD] = ~pin_cmd[msm_pkg::LANE_DCD];
            repeat (40)
            begin
                step(1);
                if (rate && !pr) cr++;
                if (mf && !pm) cm++;
                if (rx_tick) cx++;
                pr = rate;
                pm = mf;
            end
            check(8'(cr), 8'(40 / d));
            check(8'(cm), 8'(40 / d));
            check(8'(cx), 8'(40 / d));
        end
    endtask

    // Reset in mid-run with the auxiliary active and a carrier flag
    // pending: pin, flags and interrupt drop at once, with no edge
    task automatic t_mid_reset;
        alt_select_i = 2'h0;
        aux_control_i = 1'b1;
        step(1);
        check({7'h0, mf}, 8'h00);
        reset_i = 1'b1;
        #20;
        check({7'h0, mf}, 8'h01);
        check(status, 8'h00);
        check({7'h0, irq}, 8'h00);
        step(2);
        reset_i = 1'b0;
        step(1);
        check({7'h0, mf}, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Run takes about 170 cycles; 4000 leaves ample room
    initial
    begin
        #400000;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        reset_i = 1'b1;
        pin_cmd = 4'hf;
        status_read_i = 1'b0;
        msi_enable_i = 1'b0;
        aux_control_i = 1'b0;
        loopback_i = 1'b0;
        alt_select_i = 2'h0;
        divisor_i = 16'h0004;
        dma_req = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #10;
        reset_i = 1'b0;
        step(5);
        t_reset();
        t_dsr();
        t_dcd();
        t_ri();
        t_cts();
        t_mux();
        t_rate();
        t_mid_reset();
        wrap_up();
    end

endmodule // tb_top

`default_nettype wire
